// file: hw/eeprom_host_pkg.sv
// Constants for the parallel EEPROM host controller
package eeprom_host_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 6;
  localparam int POLL_BIT = 7;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------
  // Timing figures
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int ACC_NS = 150;
  localparam int WP_NS = 100;
  localparam int WPH_NS = 50;
  localparam int DF_NS = 50;
  localparam int BLC_US = 150;
  localparam int PROG_MS = 10;

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_CYC = ACC_CYC + SYNC_STAGES;
  localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DF_CYC = (DF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLC_CYC = (BLC_US * 1000) / CLK_PERIOD_NS;
  localparam int PROG_CYC = (PROG_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Timer widths
  // ----------------------------------------
  localparam int PH_W = 5;
  localparam int LT_W = 21;

endpackage : eeprom_host_pkg

// file: hw/strobe_timer.sv
// Loadable down-counter used to pace pin phases
module strobe_timer #(
  parameter int W = 5
) (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  // Load
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
    begin
      cnt_d = load_val;
    end
    else if (cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_q <= '0;
    end
    else if (en)
    begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == '0);

endmodule : strobe_timer

// file: hw/eeprom_host.sv
// Host controller driving a byte-wide parallel EEPROM through its pins
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int GAP_CYCLES = eeprom_host_pkg::BLC_CYC,
  parameter int PROG_CYCLES = eeprom_host_pkg::PROG_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic en,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_last,
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] req_addr,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] req_wdata,
  // User answer and status
  output logic resp_valid,
  output logic [eeprom_host_pkg::DATA_W-1:0] resp_rdata,
  output logic busy,
  output logic prog_timeout,
  // Memory pins
  output logic [eeprom_host_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic [eeprom_host_pkg::DATA_W-1:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] mem_dq_in
);

  import eeprom_host_pkg::*;

  localparam int PAGE_W = ADDR_W - PAGE_LSB;

  typedef enum logic [2:0] {
    S_IDLE, S_READ, S_FLOAT, S_WR_LOW, S_WR_HIGH, S_OPEN, S_POLL_RD, S_POLL_GAP
  } state_t;

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_t st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d, last_addr_q, last_addr_d;
  logic [DATA_W-1:0] data_q, data_d, rdata_q, rdata_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dq_oe_q, dq_oe_d;
  logic open_q, open_d, close_q, close_d, last_bit_q, last_bit_d;
  logic resp_q, resp_d, tmo_q, tmo_d;
  logic [DATA_W-1:0] dq_meta_q, dq_sync_q;
  logic ph_load, ph_exp, lt_load, lt_exp;
  logic [PH_W-1:0] ph_val;
  logic [LT_W-1:0] lt_val;
  logic same_page, take, start_wr, start_poll;

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  strobe_timer #(.W(PH_W)) u_phase (
    .clk(clk),
    .srst(srst),
    .en(en),
    .load(ph_load),
    .load_val(ph_val),
    .expired(ph_exp)
  );

  strobe_timer #(.W(LT_W)) u_long (
    .clk(clk),
    .srst(srst),
    .en(en),
    .load(lt_load),
    .load_val(lt_val),
    .expired(lt_exp)
  );

  // ----------------------------------------
  // Request acceptance
  // ----------------------------------------
  assign same_page = (req_addr[ADDR_W-1:PAGE_LSB] == page_q);
  assign req_ready = (st_q == S_IDLE) ||
                     ((st_q == S_OPEN) && req_write && same_page && !lt_exp);
  assign take = req_valid && req_ready && en;
  assign start_wr = take && req_write;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    addr_d = addr_q;
    last_addr_d = last_addr_q;
    data_d = data_q;
    rdata_d = rdata_q;
    page_d = page_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    dq_oe_d = dq_oe_q;
    open_d = open_q;
    close_d = close_q;
    last_bit_d = last_bit_q;
    resp_d = 1'b0;
    tmo_d = tmo_q;
    ph_load = 1'b0;
    ph_val = '0;
    lt_load = 1'b0;
    lt_val = '0;
    start_poll = 1'b0;
    unique case (st_q)
      S_IDLE:
      begin
        if (take && !req_write)
        begin
          addr_d = req_addr;
          ce_n_d = 1'b0;
          oe_n_d = 1'b0;
          ph_load = 1'b1;
          ph_val = PH_W'(RD_CYC - 1);
          st_d = S_READ;
        end
      end
      S_READ:
      begin
        if (ph_exp)
        begin
          rdata_d = dq_sync_q;
          resp_d = 1'b1;
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          ph_load = 1'b1;
          ph_val = PH_W'(DF_CYC - 1);
          st_d = S_FLOAT;
        end
      end
      S_FLOAT:
      begin
        if (ph_exp)
        begin
          st_d = S_IDLE;
        end
      end
      S_WR_LOW:
      begin
        if (ph_exp)
        begin
          we_n_d = 1'b1;
          ce_n_d = 1'b1;
          oe_n_d = 1'b0;
          dq_oe_d = 1'b0;
          ph_load = 1'b1;
          ph_val = PH_W'(WPH_CYC - 1);
          lt_load = 1'b1;
          lt_val = LT_W'(GAP_CYCLES - 1);
          st_d = S_WR_HIGH;
        end
      end
      S_WR_HIGH:
      begin
        if (ph_exp)
        begin
          start_poll = close_q;
          st_d = S_OPEN;
        end
      end
      S_OPEN:
      begin
        if (!start_wr && lt_exp)
        begin
          start_poll = 1'b1;
        end
      end
      S_POLL_RD:
      begin
        if (ph_exp)
        begin
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          ph_load = 1'b1;
          ph_val = PH_W'(DF_CYC - 1);
          if (dq_sync_q[POLL_BIT] == last_bit_q)
          begin
            st_d = S_FLOAT;
          end
          else if (lt_exp)
          begin
            tmo_d = 1'b1;
            st_d = S_FLOAT;
          end
          else
          begin
            st_d = S_POLL_GAP;
          end
        end
      end
      S_POLL_GAP:
      begin
        if (ph_exp)
        begin
          ce_n_d = 1'b0;
          oe_n_d = 1'b0;
          ph_load = 1'b1;
          ph_val = PH_W'(RD_CYC - 1);
          st_d = S_POLL_RD;
        end
      end
    endcase
    if (start_wr)
    begin
      addr_d = req_addr;
      last_addr_d = req_addr;
      data_d = req_wdata;
      last_bit_d = req_wdata[POLL_BIT];
      page_d = req_addr[ADDR_W-1:PAGE_LSB];
      dq_oe_d = 1'b1;
      ce_n_d = 1'b0;
      we_n_d = 1'b0;
      oe_n_d = 1'b1;
      open_d = 1'b1;
      close_d = req_last;
      tmo_d = 1'b0;
      ph_load = 1'b1;
      ph_val = PH_W'(WP_CYC - 1);
      st_d = S_WR_LOW;
    end
    if (start_poll)
    begin
      addr_d = last_addr_q;
      ce_n_d = 1'b0;
      oe_n_d = 1'b0;
      open_d = 1'b0;
      ph_load = 1'b1;
      ph_val = PH_W'(RD_CYC - 1);
      lt_load = 1'b1;
      lt_val = LT_W'(PROG_CYCLES - 1);
      st_d = S_POLL_RD;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= S_IDLE;
      addr_q <= '0;
      last_addr_q <= '0;
      data_q <= '0;
      rdata_q <= '0;
      page_q <= '0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_oe_q <= 1'b0;
      open_q <= 1'b0;
      close_q <= 1'b0;
      last_bit_q <= 1'b0;
      resp_q <= 1'b0;
      tmo_q <= 1'b0;
      dq_meta_q <= '0;
      dq_sync_q <= '0;
    end
    else if (en)
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      last_addr_q <= last_addr_d;
      data_q <= data_d;
      rdata_q <= rdata_d;
      page_q <= page_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dq_oe_q <= dq_oe_d;
      open_q <= open_d;
      close_q <= close_d;
      last_bit_q <= last_bit_d;
      resp_q <= resp_d;
      tmo_q <= tmo_d;
      dq_meta_q <= mem_dq_in;
      dq_sync_q <= dq_meta_q;
    end
  end

  assign mem_addr = addr_q;
  assign mem_ce_n = ce_n_q;
  assign mem_oe_n = oe_n_q;
  assign mem_we_n = we_n_q;
  assign mem_dq_out = data_q;
  assign mem_dq_oe = dq_oe_q;
  assign resp_valid = resp_q;
  assign resp_rdata = rdata_q;
  assign busy = (st_q != S_IDLE);
  assign prog_timeout = tmo_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [LT_W-1:0] gap_q;

  always_ff @(posedge clk)
  begin
    if (srst || !we_n_q)
    begin
      gap_q <= '0;
    end
    else if (en && open_q && gap_q != '1)
    begin
      gap_q <= gap_q + 1'b1;
    end
  end

  sequence s_read_start;
    $fell(oe_n_q) && !ce_n_q && we_n_q;
  endsequence

  sequence s_read_end;
    $rose(oe_n_q) && !$past(ce_n_q);
  endsequence

  property p_page_fixed;
    @(posedge clk) disable iff (srst)
    ($fell(we_n_q) && $past(open_q)) |-> (addr_q[ADDR_W-1:PAGE_LSB] == $past(page_q));
  endproperty
  a_page_fixed: assert property (p_page_fixed) else $error("page moved in load");

  property p_oe_load;
    @(posedge clk) disable iff (srst)
    (open_q && oe_n_q) |-> (!we_n_q && !ce_n_q);
  endproperty
  a_oe_load: assert property (p_oe_load) else $error("enable high outside pulse");

  property p_gap;
    @(posedge clk) disable iff (srst)
    ($fell(we_n_q) && $past(open_q)) |-> ($past(gap_q) < LT_W'(GAP_CYCLES));
  endproperty
  a_gap: assert property (p_gap) else $error("byte load window exceeded");

  property p_float;
    @(posedge clk) disable iff (srst)
    s_read_end |-> (!mem_dq_oe) [*7];
  endproperty
  a_float: assert property (p_float) else $error("drive before float time");

  property p_strobe_pair;
    @(posedge clk) disable iff (srst)
    !we_n_q |-> (!ce_n_q && oe_n_q && mem_dq_oe);
  endproperty
  a_strobe_pair: assert property (p_strobe_pair) else $error("bad write pulse");

  property p_read_wait;
    @(posedge clk) disable iff (srst)
    s_read_start |-> (!oe_n_q && !ce_n_q) [*8];
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read cut short");

  property p_poll_addr;
    @(posedge clk) disable iff (srst)
    (st_q == S_POLL_RD) |-> (addr_q == last_addr_q && we_n_q && !mem_dq_oe);
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("poll on wrong byte");

endmodule : eeprom_host

// file: testbench/eeprom_dev_model.sv
// Behavioural model of the byte-wide EEPROM on the host pins
module eeprom_dev_model
  import eeprom_host_pkg::*;
#(
  parameter int GAP = 64,
  parameter int PROG = 600,
  parameter int ACC = 15
) (
  // Clock and fault control
  input wire logic clk,
  input wire logic stuck,
  // Pins
  input wire logic [eeprom_host_pkg::ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [eeprom_host_pkg::DATA_W-1:0] dq_w,
  output logic [eeprom_host_pkg::DATA_W-1:0] dq_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [8192];
  logic [7:0] pbuf [64];
  logic [63:0] pv;
  logic [6:0] page;
  logic [12:0] a_lat;
  logic [12:0] last_a;
  logic [7:0] last_d;
  logic [7:0] rd;
  logic [7:0] d_lat;
  logic wr_q = 0;
  logic loading = 0;
  int gap_c = 0;
  int prog_c = 0;
  int acc_c = 0;
  wire strobe = !ce_n && !we_n && oe_n;

  initial
  begin
    for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h5A;
    dq_r = '0;
  end

  always @(posedge clk)
  begin
    if (strobe && !wr_q) a_lat = addr;
    if (strobe) d_lat = dq_w;
    if (!strobe && wr_q && prog_c == 0)
    begin
      if (!loading) pv = '0;
      if (!loading) page = a_lat[12:6];
      pbuf[a_lat[5:0]] = d_lat;
      pv[a_lat[5:0]] = 1'b1;
      last_a = {page, a_lat[5:0]};
      last_d = d_lat;
      loading = 1;
      gap_c = 0;
    end
    else if (loading && gap_c >= GAP)
    begin
      for (int i = 0; i < 64; i++) if (pv[i]) mem[{page, i[5:0]}] = pbuf[i];
      loading = 0;
      prog_c = PROG;
    end
    else if (loading) gap_c++;
    else if (prog_c > 0 && !stuck) prog_c--;
    wr_q = strobe;
    acc_c = (!ce_n && !oe_n && we_n) ? acc_c + 1 : 0;
    rd = mem[addr];
    if ((loading || prog_c > 0) && addr == last_a) rd = {~last_d[7], last_d[6:0]};
    if (acc_c > ACC) dq_r <= rd;
    else dq_r <= ~dq_r;
  end
endmodule : eeprom_dev_model

// file: testbench/eeprom_host_tb_top.sv
// Self-checking bench for the EEPROM host controller
module eeprom_host_tb_top;
  import eeprom_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = 64;
  localparam int PROG = 2000;
  localparam int DPROG = 600;
  logic clk = 0;
  logic srst = 1;
  logic en = 1;
  logic req_valid = 0;
  logic req_write = 0;
  logic req_last = 0;
  logic stuck = 0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic req_ready, resp_valid, busy, prog_timeout, mem_ce_n, mem_oe_n, mem_we_n, mem_dq_oe;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] resp_rdata, mem_dq_out, dev_q, dq_bus;
  int failures = 0;
  int n_checks = 0;
  assign dq_bus = mem_dq_oe ? mem_dq_out : dev_q;
  always #4 clk = ~clk;

  eeprom_host #(.GAP_CYCLES(GAP), .PROG_CYCLES(PROG)) uut (.clk(clk), .srst(srst), .en(en),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_last(req_last),
    .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .busy(busy), .prog_timeout(prog_timeout), .mem_addr(mem_addr),
    .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n),
    .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(dq_bus));
  eeprom_dev_model #(.GAP(GAP), .PROG(DPROG), .ACC(15)) dev (.clk(clk), .stuck(stuck),
    .addr(mem_addr), .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .dq_w(dq_bus),
    .dq_r(dev_q));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic give_up(input string what);
    failures++;
    $display("unexpected %s expected done seen timeout", what);
    conclude();
  endtask : give_up

  task automatic send(input logic wr, input logic last, input logic [12:0] a,
                      input logic [7:0] d);
    int i;
    @(negedge clk);
    req_valid = 1;
    req_write = wr;
    req_last = last;
    req_addr = a;
    req_wdata = d;
    #1;
    i = 0;
    while (req_ready !== 1'b1 && i < 5000)
    begin
      @(negedge clk);
      i++;
    end
    if (req_ready !== 1'b1) give_up("ready");
    @(negedge clk);
    req_valid = 0;
  endtask : send

  task automatic wait_idle(input int lim, output int n);
    n = 0;
    while (busy !== 1'b0 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (busy !== 1'b0) give_up("idle");
  endtask : wait_idle

  task automatic do_read(input logic [12:0] a, input logic [7:0] exp, input int stall);
    int n;
    send(0, 0, a, 8'h00);
    if (stall > 0)
    begin
      en = 0;
      repeat (stall) @(negedge clk);
      en = 1;
    end
    n = stall;
    while (resp_valid !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    if (resp_valid !== 1'b1) give_up("answer");
    check("read latency", n, RD_CYC + stall);
    check("read data", resp_rdata, exp);
    wait_idle(100, n);
  endtask : do_read

  task automatic t_idle();
    check("idle strobes", {mem_ce_n, mem_oe_n, mem_we_n}, 3'b111);
    check("idle drive", {mem_dq_oe, busy, req_ready}, 3'b001);
    $display("test idle done");
  endtask : t_idle

  task automatic t_reads();
    do_read(13'h0000, 8'h5A, 0);
    do_read(13'h1FFF, 8'hA5, 0);
    do_read(13'h00A5, 8'hFF, 5);
    $display("test reads done");
  endtask : t_reads

  task automatic t_page();
    logic [12:0] a [4] = '{13'h07FF, 13'h07C0, 13'h07D1, 13'h07C5};
    int n;
    for (int i = 0; i < 4; i++) send(1, i == 3, a[i], {i[1:0], 6'h15});
    wait_idle(PROG + GAP, n);
    check("poll wait", n >= DPROG, 1);
    check("no timeout", prog_timeout, 0);
    for (int i = 0; i < 4; i++) do_read(a[i], {i[1:0], 6'h15}, 0);
    do_read(13'h07C1, 8'h9B, 0);
    $display("test page done");
  endtask : t_page

  task automatic t_gap();
    int n;
    send(1, 0, 13'h0203, 8'h96);
    send(1, 0, 13'h0204, 8'h69);
    wait_idle(PROG + GAP + 100, n);
    check("gap wait", n >= GAP, 1);
    do_read(13'h0203, 8'h96, 0);
    do_read(13'h0204, 8'h69, 0);
    $display("test gap done");
  endtask : t_gap

  task automatic t_timeout();
    int n;
    stuck = 1;
    send(1, 1, 13'h1000, 8'hC3);
    wait_idle(PROG + 300, n);
    check("timeout flag", prog_timeout, 1);
    stuck = 0;
    repeat (DPROG + GAP) @(negedge clk);
    send(1, 1, 13'h1000, 8'h3C);
    check("timeout clear", prog_timeout, 0);
    wait_idle(PROG + GAP, n);
    do_read(13'h1000, 8'h3C, 0);
    $display("test timeout done");
  endtask : t_timeout

  initial
  begin
    repeat (12) @(negedge clk);
    srst = 0;
    @(negedge clk);
    t_idle();
    t_reads();
    t_page();
    t_gap();
    t_timeout();
    conclude();
  end
endmodule : eeprom_host_tb_top
